// File: nvm_clk_pkg.sv
// Shared constants and types for the NVM clock divider and lock monitor.
// Assumes a single 40 MHz system clock and a word-aligned AHB-Lite register bus.
package nvm_clk_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int          SYS_CLK_KHZ        = 40000;     // System clock rate
  localparam int          SM_CLK_MIN_KHZ     = 150;       // Lowest allowed state machine clock
  localparam int          SM_CLK_MAX_KHZ     = 200;       // Highest allowed state machine clock
  localparam int          SM_CLK_MARGIN_PCT  = 6;         // Headroom below the maximum
  localparam int          DIV_W              = 6;         // Divider modulus width
  localparam int          CNT_W              = 15;        // Operation cycle counter width
  localparam logic [14:0] BYTE_PROG_CYCLES   = 15'h0009;  // Byte program, in state machine clocks
  localparam logic [14:0] BURST_NEXT_CYCLES  = 15'h0004;  // Later bytes of a burst
  localparam logic [14:0] SECTOR_ERASE_CYCLES = 15'h0fa0; // Sector erase, 4000 clocks
  localparam int          MASS_ERASE_CYCLES  = 20000;     // Mass erase, default of a top parameter

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_BYTE_PROG    = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG   = 8'h25;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

  // ==========================================================================
  // Register map (byte offsets)
  // ==========================================================================
  localparam logic [7:0] OFF_DIV    = 8'h00;  // nvm_clock_divider_reg
  localparam logic [7:0] OFF_STAT   = 8'h04;  // clock_gen_status_reg
  localparam logic [7:0] OFF_CTRL3  = 8'h08;  // clock_gen_control3_reg
  localparam logic [7:0] OFF_PRESC  = 8'h0c;  // Bus clock prescale select
  localparam logic [7:0] OFF_CMD    = 8'h10;  // NVM command launch and status

  // Field positions
  localparam int DIV_LOADED_BIT = 7;  // Divider has been written
  localparam int ST_LOCK_BIT    = 0;  // Live lock level
  localparam int ST_LOL_BIT     = 1;  // loss_of_lock_flag
  localparam int ST_DONE_BIT    = 2;  // Operation complete
  localparam int ST_REFUSE_BIT  = 3;  // Launch refused
  localparam int ST_W           = 4;  // Status and mask width
  localparam int CMD_BUSY_BIT   = 8;
  localparam int CMD_PEND_BIT   = 9;

  // Reset values
  localparam logic [5:0]      DIV_RST   = 6'h00;
  localparam logic [1:0]      PRESC_RST = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST  = 4'h0;

  // Captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } ahb_phase_t;

endpackage

// File: mod_divider.sv
// Modulus down-counter that emits one-cycle ticks.
// Assumes the same clock and reset as the parent; modulus may change at any time.
`timescale 1ns/10ps
module mod_divider #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         enable,
  input  wire logic [W-1:0] modulus,
  output logic              tick
);

  logic [W-1:0] count_q;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Reload at terminal count so the period is modulus plus one enabled cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= enable && (count_q == '0);
      if (enable)
      begin
        count_q <= (count_q == '0) ? modulus : count_q - 1'b1;
      end
    end
  end

endmodule // mod_divider

// File: nvm_clock_divider_lock_monitor.sv
// NVM state machine clock divider, bus clock prescaler, operation timer and
// loss-of-lock monitor behind an AHB-Lite slave.
// Assumes lockPin and lowVoltPin are asynchronous and the bus has one master.
// Function
// - State machine clock from bus clock divider
// - Divider register accepts only first write
// - Bus clock prescale by one, two, four, eight
// - Sticky loss-of-lock flag, write one clears
// - Interrupt when flag and enable both set
// - Low voltage refuses new operations only
// - Sector erase lasts 4000 state machine clocks
// - Byte nine clocks, burst follow-on four
`timescale 1ns/10ps
module nvm_clock_divider_lock_monitor #(
  parameter int MASS_CYCLES = nvm_clk_pkg::MASS_ERASE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        lockPin,
  input  wire logic        lowVoltPin,
  output logic             busClockTick,
  output logic             stateMachineClock,
  output logic             nvmBusy,
  output logic             irq
);

  typedef enum logic {IDLE, RUN} seq_state_t;

  nvm_clk_pkg::ahb_phase_t      dp_q;
  logic                         rdWait_q;
  logic [5:0]                   div_q;
  logic                         divLoaded_q;
  logic [1:0]                   presc_q;
  logic [nvm_clk_pkg::ST_W-1:0] mask_q;
  logic                         lol_q;
  logic                         done_q;
  logic                         refuse_q;
  logic [1:0]                   lockMeta_q;
  logic [1:0]                   lvMeta_q;
  logic                         lockPrev_q;
  seq_state_t                   state_q;
  logic [7:0]                   code_q;
  logic [14:0]                  remaining_q;
  logic                         curBurst_q;
  logic                         pending_q;
  logic [31:0]                  readMux;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Two stages each; only bit 1 is read by logic
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lockMeta_q <= 2'h0;
      lvMeta_q   <= 2'h0;
      lockPrev_q <= 1'b0;
    end
    else
    begin
      lockMeta_q <= {lockMeta_q[0], lockPin};
      lvMeta_q   <= {lvMeta_q[0], lowVoltPin};
      lockPrev_q <= lockMeta_q[1];
    end
  end

  wire lockSync    = lockMeta_q[1];
  wire lowVoltSync = lvMeta_q[1];
  wire lolSet      = lockPrev_q && !lockSync;  // Loop left lock tolerance

  // ==========================================================================
  // AHB-Lite address and data phase
  // ==========================================================================
  wire        addrTaken = hsel && htrans[1] && hready;
  wire        rdData    = dp_q.valid && !dp_q.write;
  wire        wrData    = dp_q.valid && dp_q.write;
  wire        selDiv    = dp_q.addr == nvm_clk_pkg::OFF_DIV;
  wire        selStat   = dp_q.addr == nvm_clk_pkg::OFF_STAT;
  wire        selCtrl3  = dp_q.addr == nvm_clk_pkg::OFF_CTRL3;
  wire        selPresc  = dp_q.addr == nvm_clk_pkg::OFF_PRESC;
  wire        selCmd    = dp_q.addr == nvm_clk_pkg::OFF_CMD;
  wire        wrDiv     = wrData && selDiv;
  wire        wrStat    = wrData && selStat;
  wire        wrCtrl3   = wrData && selCtrl3;
  wire        wrPresc   = wrData && selPresc;
  wire        wrCmd     = wrData && selCmd;

  // Capture the address phase; reads get one wait state so data comes from a flop
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dp_q      <= '0;
      rdWait_q  <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        dp_q.valid <= addrTaken;
        dp_q.write <= hwrite;
        dp_q.addr  <= {haddr[7:2], 2'b00};
      end
      rdWait_q  <= addrTaken && !hwrite;
      hreadyout <= !(addrTaken && !hwrite);
      hresp     <= 1'b0;
      if (rdWait_q)
      begin
        hrdata <= readMux;
      end
    end
  end

  // ==========================================================================
  // Read data selection
  // ==========================================================================
  wire [31:0] divRead   = {24'h000000, divLoaded_q, 1'b0, div_q};
  wire [3:0]  statBits  = {refuse_q, done_q, lol_q, lockSync};
  wire [31:0] statRead  = {28'h0000000, statBits};
  wire [31:0] ctrl3Read = {28'h0000000, mask_q[3:1], 1'b0};
  wire [31:0] prescRead = {30'h00000000, presc_q};
  wire [31:0] cmdRead   = {22'h000000, pending_q, nvmBusy, code_q};
  assign readMux        = selDiv   ? divRead   :
                          selStat  ? statRead  :
                          selCtrl3 ? ctrl3Read :
                          selPresc ? prescRead :
                          selCmd   ? cmdRead   : 32'h0000_0000;

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // The divider latches once per reset; later writes fall away
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q       <= nvm_clk_pkg::DIV_RST;
      divLoaded_q <= 1'b0;
      presc_q     <= nvm_clk_pkg::PRESC_RST;
      mask_q      <= nvm_clk_pkg::MASK_RST;
    end
    else
    begin
      if (wrDiv && !divLoaded_q)
      begin
        div_q       <= hwdata[5:0];
        divLoaded_q <= 1'b1;
      end
      if (wrPresc)
      begin
        presc_q <= hwdata[1:0];
      end
      if (wrCtrl3)
      begin
        mask_q <= {hwdata[3:1], 1'b0};  // Lock level itself never interrupts
      end
    end
  end

  // ==========================================================================
  // Clock dividers
  // ==========================================================================
  // Bus clock modulus: 0, 1, 3, 7 gives divide by 1, 2, 4, 8
  wire [2:0] prescMod = 3'(({1'b0, 2'b00} + 3'h1 << presc_q) - 3'h1);
  wire       smClkEnable = busClockTick && divLoaded_q;

  mod_divider #(.W(3)) u_bus_div (
    .clk     (sys_clk),
    .rst     (sys_rst),
    .enable  (1'b1),
    .modulus (prescMod),
    .tick    (busClockTick)
  );

  // State machine clock counts bus ticks down from the written modulus
  mod_divider #(.W(nvm_clk_pkg::DIV_W)) u_sm_div (
    .clk     (sys_clk),
    .rst     (sys_rst),
    .enable  (smClkEnable),
    .modulus (div_q),
    .tick    (stateMachineClock)
  );

  // ==========================================================================
  // Command launch decode
  // ==========================================================================
  wire [7:0]  cmdCode   = hwdata[7:0];
  wire        isByte    = cmdCode == nvm_clk_pkg::CMD_BYTE_PROG;
  wire        isBurst   = cmdCode == nvm_clk_pkg::CMD_BURST_PROG;
  wire        isSector  = cmdCode == nvm_clk_pkg::CMD_SECTOR_ERASE;
  wire        isMass    = cmdCode == nvm_clk_pkg::CMD_MASS_ERASE;
  wire        known     = isByte || isBurst || isSector || isMass;
  wire        launchOk  = divLoaded_q && !lowVoltSync;
  wire        canStart  = wrCmd && known && launchOk && (state_q == IDLE);
  wire        canQueue  = wrCmd && isBurst && launchOk && (state_q == RUN) && curBurst_q && !pending_q;
  wire        refuseEvt = wrCmd && !canStart && !canQueue;
  wire [14:0] startLen  = isSector ? nvm_clk_pkg::SECTOR_ERASE_CYCLES :
                          isMass   ? 15'(MASS_CYCLES) :
                                     nvm_clk_pkg::BYTE_PROG_CYCLES;
  wire        lastTick  = (state_q == RUN) && stateMachineClock && (remaining_q == 15'h0001);
  wire        doneEvt   = lastTick && !pending_q;

  // ==========================================================================
  // Operation sequencer
  // ==========================================================================
  // Counts state machine clocks; a queued burst byte keeps the pump on
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= IDLE;
      nvmBusy     <= 1'b0;
      code_q      <= 8'h00;
      remaining_q <= 15'h0000;
      curBurst_q  <= 1'b0;
      pending_q   <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (canStart)
          begin
            state_q     <= RUN;
            nvmBusy     <= 1'b1;
            code_q      <= cmdCode;
            remaining_q <= startLen;
            curBurst_q  <= isBurst;
          end
        end
        RUN:
        begin
          if (canQueue)
          begin
            pending_q <= 1'b1;
          end
          if (lastTick && pending_q)
          begin
            remaining_q <= nvm_clk_pkg::BURST_NEXT_CYCLES;
            pending_q   <= 1'b0;
          end
          else if (lastTick)
          begin
            state_q    <= IDLE;
            nvmBusy    <= 1'b0;
            curBurst_q <= 1'b0;
          end
          else if (stateMachineClock)
          begin
            remaining_q <= remaining_q - 15'h0001;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Sticky status and interrupt
  // ==========================================================================
  // Setting event beats a write-one clear in the same cycle
  wire [3:0] clrBits = wrStat ? hwdata[3:0] : 4'h0;
  wire [3:0] pending = statBits & mask_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lol_q    <= 1'b0;
      done_q   <= 1'b0;
      refuse_q <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      lol_q    <= lolSet || (lol_q && !clrBits[nvm_clk_pkg::ST_LOL_BIT]);
      done_q   <= doneEvt || (done_q && !clrBits[nvm_clk_pkg::ST_DONE_BIT]);
      refuse_q <= refuseEvt || (refuse_q && !clrBits[nvm_clk_pkg::ST_REFUSE_BIT]);
      irq      <= |pending;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic [14:0] opTicks_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opTicks_q <= 15'h0000;
    end
    else
    begin
      opTicks_q <= canStart ? 15'h0000 : opTicks_q + 15'((state_q == RUN) && stateMachineClock);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  smclk_spacing_a: assert property ((divLoaded_q && div_q != 6'h00 && stateMachineClock) |=> !stateMachineClock)
    else $error("state machine clock ticks too close");
  smclk_held_a: assert property (!divLoaded_q |-> !stateMachineClock)
    else $error("state machine clock runs before divider write");
  div_once_a: assert property ((divLoaded_q && wrDiv) |=> $stable(div_q))
    else $error("divider changed after first write");
  div_first_a: assert property ((!divLoaded_q && wrDiv) |=> divLoaded_q && div_q == $past(hwdata[5:0]))
    else $error("first divider write not taken");
  bus_prescale_a: assert property ((busClockTick && presc_q == 2'h3 && $stable(presc_q)) |=> !busClockTick [*3])
    else $error("divide by eight prescale ticks early");
  lol_sticky_a: assert property ((lol_q && !clrBits[1]) |=> lol_q)
    else $error("loss-of-lock flag dropped without clear");
  lol_set_a: assert property (lolSet |=> lol_q)
    else $error("loss-of-lock flag not set");
  lol_irq_a: assert property ((lol_q && mask_q[1]) |=> irq)
    else $error("loss-of-lock interrupt missing");
  irq_quiet_a: assert property ((pending == 4'h0) |=> !irq)
    else $error("interrupt without unmasked status");
  lowvolt_block_a: assert property ((wrCmd && lowVoltSync && !nvmBusy) |=> !nvmBusy)
    else $error("operation launched under low voltage");
  byte_len_a: assert property (($fell(nvmBusy) && code_q == 8'h20) |-> opTicks_q == 15'h0009)
    else $error("byte program length wrong");
  erase_len_a: assert property (($fell(nvmBusy) && code_q == 8'h40) |-> opTicks_q == 15'h0fa0)
    else $error("sector erase length wrong");

  smclk_run_c:  cover property (stateMachineClock ##1 !stateMachineClock);
  op_done_c:    cover property (doneEvt);
  burst_chain_c: cover property (canQueue ##[1:1000] (lastTick && pending_q));
  lol_irq_c:    cover property (lolSet ##[1:4] irq);

endmodule // nvm_clock_divider_lock_monitor

// File: tb_top.sv
// Self-checking testbench for the NVM clock divider and lock monitor.
// Assumes the design's AHB-Lite slave, hready looped from hreadyout, one 40 MHz clock.
`timescale 1ns/10ps
module tb_top;
  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  localparam int massCycles = 20;  // Short mass erase for simulation
  logic        sys_clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  wire  logic  hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        lockPin;
  logic        lowVoltPin;
  logic        busClockTick;
  logic        stateMachineClock;
  logic        nvmBusy;
  logic        irq;
  int          failures;
  int          cmp_count;
  int          cycleCount;
  int          busCnt;
  int          smCnt;
  int          busyTicks;
  int          smKhz;
  logic [31:0] rdVal;

  assign hready = hreadyout;

  nvm_clock_divider_lock_monitor #(.MASS_CYCLES(massCycles)) i_dut (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hready            (hready),
    .hwdata            (hwdata),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .lockPin           (lockPin),
    .lowVoltPin        (lowVoltPin),
    .busClockTick      (busClockTick),
    .stateMachineClock (stateMachineClock),
    .nvmBusy           (nvmBusy),
    .irq               (irq)
  );

  // ==========================================================================
  // Clock, tick monitors and hang guard
  // ==========================================================================
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Counts ticks on each rising edge; the sequence clears the counts between edges
  always @(posedge sys_clk)
  begin
    if (busClockTick === 1'b1) busCnt <= busCnt + 1;
    if (stateMachineClock === 1'b1) smCnt <= smCnt + 1;
    if (stateMachineClock === 1'b1 && nvmBusy === 1'b1) busyTicks <= busyTicks + 1;
    cycleCount <= cycleCount + 1;
    if (cycleCount == 40000)
    begin
      failures = failures + 1;
      end_of_test();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One AHB-Lite single transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, off};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, off, wd, unused);
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, off, 32'h0, got);
    chk(got, exp);
  endtask

  task automatic clear_counts();
    @(negedge sys_clk);
    busCnt = 0;
    smCnt = 0;
    busyTicks = 0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (nvmBusy !== 1'b0 && n < 30000)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    @(negedge sys_clk);
  endtask

  task automatic reset_dut();
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask

  // Launches one operation and checks its length in state machine clocks
  task automatic run_op(input logic [7:0] code, input int exp);
    clear_counts();
    wr(nvm_clk_pkg::OFF_CMD, {24'h000000, code});
    @(negedge sys_clk);
    chk({31'h0, nvmBusy}, 32'h1);
    wait_idle();
    chk(busyTicks, exp);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h5);
    wr(nvm_clk_pkg::OFF_STAT, 32'h4);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lockPin = 1'b1;
    lowVoltPin = 1'b0;
    failures = 0;
    cmp_count = 0;
    cycleCount = 0;
    busCnt = 0;
    smCnt = 0;
    busyTicks = 0;
    reset_dut();
    // Reset values and the unmapped hole
    rd_chk(nvm_clk_pkg::OFF_DIV, 32'h0);
    rd_chk(nvm_clk_pkg::OFF_CTRL3, 32'h0);
    rd_chk(nvm_clk_pkg::OFF_PRESC, 32'h0);
    rd_chk(8'h20, 32'h0);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h1);
    // No state machine clock until the divider is written
    clear_counts();
    repeat (128) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(smCnt, 0);
    chk(busCnt, 128);
    wr(nvm_clk_pkg::OFF_CMD, 32'h20);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h9);
    chk({31'h0, nvmBusy}, 32'h0);
    // Divider takes only the first write
    wr(nvm_clk_pkg::OFF_DIV, 32'h3);
    wr(nvm_clk_pkg::OFF_DIV, 32'h5);
    wr(8'h20, 32'hff);
    rd_chk(nvm_clk_pkg::OFF_DIV, 32'h83);
    wr(nvm_clk_pkg::OFF_STAT, 32'hf);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h1);
    // Every prescale setting, with the divider period on top
    for (int p = 0; p < 4; p++)
    begin
      wr(nvm_clk_pkg::OFF_PRESC, p);
      rd_chk(nvm_clk_pkg::OFF_PRESC, p);
      repeat (16) @(posedge sys_clk);
      clear_counts();
      repeat (128) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(busCnt, 128 >> p);
      chk(smCnt, (128 >> p) / 4);
    end
    wr(nvm_clk_pkg::OFF_PRESC, 32'h0);
    // Operation lengths in state machine clocks
    run_op(nvm_clk_pkg::CMD_BYTE_PROG, 9);
    run_op(nvm_clk_pkg::CMD_MASS_ERASE, massCycles);
    // Burst with one queued follow-on byte
    clear_counts();
    wr(nvm_clk_pkg::OFF_CMD, 32'h25);
    wr(nvm_clk_pkg::OFF_CMD, 32'h25);
    rd_chk(nvm_clk_pkg::OFF_CMD, 32'h325);
    wait_idle();
    chk(busyTicks, 13);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h5);
    wr(nvm_clk_pkg::OFF_STAT, 32'hf);
    // Sector erase runs through a busy refusal and a low-voltage warning
    clear_counts();
    wr(nvm_clk_pkg::OFF_CMD, 32'h40);
    wr(nvm_clk_pkg::OFF_CMD, 32'h20);
    lowVoltPin <= 1'b1;
    wait_idle();
    chk(busyTicks, 4000);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'hd);
    wr(nvm_clk_pkg::OFF_STAT, 32'hf);
    wr(nvm_clk_pkg::OFF_CMD, 32'h20);
    @(negedge sys_clk);
    chk({31'h0, nvmBusy}, 32'h0);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h9);
    lowVoltPin <= 1'b0;
    wr(nvm_clk_pkg::OFF_STAT, 32'hf);
    repeat (4) @(posedge sys_clk);
    wr(nvm_clk_pkg::OFF_CMD, 32'h33);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h9);
    wr(nvm_clk_pkg::OFF_STAT, 32'hf);
    // Loss of lock: sticky flag, masked and unmasked interrupt, clear
    lockPin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    lockPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h3);
    wr(nvm_clk_pkg::OFF_CTRL3, 32'hf);
    rd_chk(nvm_clk_pkg::OFF_CTRL3, 32'he);
    chk({31'h0, irq}, 32'h1);
    wr(nvm_clk_pkg::OFF_STAT, 32'h2);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(nvm_clk_pkg::OFF_STAT, 32'h1);
    // A second reset re-arms the write-once divider
    reset_dut();
    rd_chk(nvm_clk_pkg::OFF_DIV, 32'h0);
    // In-band divider: 40 MHz / 8 / 27 is about 185 kHz, inside the margin
    wr(nvm_clk_pkg::OFF_DIV, 32'h1a);
    rd_chk(nvm_clk_pkg::OFF_DIV, 32'h9a);
    wr(nvm_clk_pkg::OFF_PRESC, 32'h3);
    repeat (16) @(posedge sys_clk);
    clear_counts();
    repeat (432) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(busCnt, 54);
    chk(smCnt, 2);
    smKhz = smCnt * nvm_clk_pkg::SYS_CLK_KHZ / 432;
    chk(32'(smKhz >= nvm_clk_pkg::SM_CLK_MIN_KHZ), 32'h1);
    chk(32'(smKhz * 100 <= nvm_clk_pkg::SM_CLK_MAX_KHZ * (100 - nvm_clk_pkg::SM_CLK_MARGIN_PCT)), 32'h1);
    rd_chk(nvm_clk_pkg::OFF_CTRL3, 32'h0);
    end_of_test();
  end
endmodule // tb_top
